// ---- hdl/pll_cgm_pkg.sv ----
// Shared constants for the clock generator control block and its partner.
// Assumes one system clock; both ends import this package.
package pll_cgm_pkg;

	// Register indices on the link
	localparam logic       REG_CTRL       = 1'b0;
	localparam logic       REG_BW         = 1'b1;

	// pll_control bit positions
	localparam int         CTRL_IRQ_EN    = 7;
	localparam int         CTRL_FLAG      = 6;
	localparam int         CTRL_LOOP_ON   = 5;
	localparam int         CTRL_BASE_SEL  = 4;
	localparam int         CTRL_PRE_HI    = 3;
	localparam int         CTRL_PRE_LO    = 2;
	localparam int         CTRL_VPR_HI    = 1;
	localparam int         CTRL_VPR_LO    = 0;

	// pll_bandwidth_control bit positions, bits 4..0 read as zero
	localparam int         BW_AUTO        = 7;
	localparam int         BW_LOCK        = 6;
	localparam int         BW_ACQ         = 5;

	// Values after reset
	localparam logic [7:0] CTRL_RESET     = 8'h20;
	localparam logic [7:0] BW_RESET       = 8'h00;
	localparam logic       LOOP_ON_RESET  = 1'b1;

	// Source edges held during a base clock hand-over
	localparam logic [1:0] HANDOVER_EDGES = 2'h3;

	// Wishbone byte offsets of the partner's registers
	localparam logic [7:0] WB_CTRL        = 8'h00;
	localparam logic [7:0] WB_BW          = 8'h04;
	localparam logic [7:0] WB_SIM_CFG     = 8'h08;
	localparam logic [7:0] WB_SIM_STAT    = 8'h0c;

	// Partner configuration bits and reset value
	localparam int         CFG_OSC_EN     = 0;
	localparam int         CFG_STOP       = 1;
	localparam int         CFG_KEEPALIVE  = 2;
	localparam logic [2:0] CFG_RESET      = 3'h1;

	// Partner status bits
	localparam int         STAT_IRQ       = 0;
	localparam int         STAT_BASE_CLK  = 1;

	typedef enum logic [1:0] {
		HO_RUN,
		HO_DRAIN_OLD,
		HO_ARM_NEW
	} handover_t;

endpackage

// ---- hdl/pll_link_if.sv ----
// Link between the clock generator control end and the system integration
// end. Both ends run on the same system clock.
`timescale 1ns/1ps
interface pll_link_if;
	logic       req;
	logic       addr;
	logic       we;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       ack;
	logic       osc_enable_in;
	logic       stop_mode;
	logic       stop_osc_keepalive;
	logic       base_clock_out;
	logic       lock_change_irq;

	modport device (
		input  req,
		input  addr,
		input  we,
		input  wdata,
		output rdata,
		output ack,
		input  osc_enable_in,
		input  stop_mode,
		input  stop_osc_keepalive,
		output base_clock_out,
		output lock_change_irq
	);

	modport sim (
		output req,
		output addr,
		output we,
		output wdata,
		input  rdata,
		input  ack,
		output osc_enable_in,
		output stop_mode,
		output stop_osc_keepalive,
		input  base_clock_out,
		input  lock_change_irq
	);
endinterface

// ---- hdl/pll_clock_control_regs.sv ----
// Clock generator control end: pll_control and pll_bandwidth_control,
// lock change flag and interrupt, base clock selector with hand-over.
// Assumes crystal, VCO, lock and acquisition inputs are asynchronous and
// the range field comes from logic on the system clock.
//
// Summary of operation
// - Partner drives oscillator enable; device obeys it.
// - Keep-alive bit keeps oscillator running in stop.
// - Base clock is selected source halved, 50 percent.
// - Interrupt enable zero, unwritable while manual mode.
// - Lock change sets flag; flag and enable interrupt.
// - Flag reads zero in manual mode; reset clears.
// - Reading control register clears the flag.
// - Loop on after reset; cannot clear while selected.
// - Select refused while loop off; two writes needed.
// - Base clock static during hand-over: three old, then three new edges.
// - Select one routes VCO, zero routes crystal.
// - Prescale field locked while loop on; reset clears.
// - VCO power field locked while on; never code 11 (code stores 11 as written).
// - Loop off or range zero forces select clear.
// - Programming register read-only while loop on.
// - Select set forces loop on, read-only.
// - Bandwidth mode bit: one automatic, zero manual.
// - Lock bit reads lock in automatic, else zero.
// - Software always writes zero to lock bit.
// - Acquire bit reports in automatic, forces in manual.
// - Stop entry with VCO selected clears the select.
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module pll_clock_control_regs
	import pll_cgm_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	pll_link_if.device      link,
	input  wire logic       crystal_clock_i,
	input  wire logic       vco_clock_i,
	input  wire logic       lock_detect_i,
	input  wire logic       acq_state_i,
	input  wire logic [7:0] vco_range_field_i,
	output logic            osc_run_o,
	output logic            pll_run_o,
	output logic            loop_on_o,
	output logic [1:0]      prescale_o,
	output logic [1:0]      vco_pow2_o,
	output logic            auto_mode_o,
	output logic            acq_force_o
);
	import pll_cgm_pkg::*;

	logic       irq_en_ff;
	logic       flag_ff;
	logic       loop_on_ff;
	logic       base_sel_ff;
	logic [1:0] prescale_ff;
	logic [1:0] vpr_ff;
	logic       auto_ff;
	logic       acq_man_ff;
	logic       ack_ff;
	logic [7:0] rdata_ff;
	logic       stop_prev_ff;
	logic [2:0] xclk_sync_ff;
	logic [2:0] vclk_sync_ff;
	logic [2:0] lock_sync_ff;
	logic [1:0] acq_sync_ff;
	logic       base_ff;
	logic       active_sel_ff;
	logic [1:0] edge_cnt_ff;
	handover_t  ho_ff;

	logic       access;
	logic       wr_ctrl;
	logic       wr_bw;
	logic       rd_ctrl;
	logic       range_zero;
	logic       halted;
	logic       stop_entry;
	logic       lock_change;
	logic       xclk_rise;
	logic       vclk_rise;
	logic       old_rise;
	logic       new_rise;
	logic       lock_view;
	logic       acq_view;
	logic [7:0] ctrl_view;
	logic [7:0] bw_view;

	assign access     = link.req && !ack_ff;
	assign wr_ctrl    = access && link.we && link.addr == REG_CTRL;
	assign wr_bw      = access && link.we && link.addr == REG_BW;
	assign rd_ctrl    = access && !link.we && link.addr == REG_CTRL;
	assign range_zero = vco_range_field_i == 8'h00;
	// Stop without keep-alive shuts the oscillator, so base clock, interrupt and osc_run_o idle low
	assign halted     = link.stop_mode && !link.stop_osc_keepalive;
	assign stop_entry = link.stop_mode && !stop_prev_ff;

	assign xclk_rise   = xclk_sync_ff[1] && !xclk_sync_ff[2];
	assign vclk_rise   = vclk_sync_ff[1] && !vclk_sync_ff[2];
	assign lock_change = lock_sync_ff[1] ^ lock_sync_ff[2];
	assign old_rise    = active_sel_ff ? vclk_rise : xclk_rise;
	assign new_rise    = active_sel_ff ? xclk_rise : vclk_rise;

	assign lock_view = auto_ff && lock_sync_ff[2];
	assign acq_view  = auto_ff ? acq_sync_ff[1] : acq_man_ff;

	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[CTRL_IRQ_EN]  = irq_en_ff && auto_ff;
		ctrl_view[CTRL_FLAG]    = flag_ff && auto_ff;
		ctrl_view[CTRL_LOOP_ON] = loop_on_ff;
		ctrl_view[CTRL_BASE_SEL] = base_sel_ff;
		ctrl_view[CTRL_PRE_HI:CTRL_PRE_LO] = prescale_ff;
		ctrl_view[CTRL_VPR_HI:CTRL_VPR_LO] = vpr_ff;
		bw_view = 8'h00;
		bw_view[BW_AUTO] = auto_ff;
		bw_view[BW_LOCK] = lock_view;
		bw_view[BW_ACQ]  = acq_view;
	end

	// Asynchronous inputs: first flop is read only by the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xclk_sync_ff <= 3'h0;
			vclk_sync_ff <= 3'h0;
			lock_sync_ff <= 3'h0;
			acq_sync_ff  <= 2'h0;
		end else if (ce_i) begin
			xclk_sync_ff <= {xclk_sync_ff[1:0], crystal_clock_i};
			vclk_sync_ff <= {vclk_sync_ff[1:0], vco_clock_i};
			lock_sync_ff <= {lock_sync_ff[1:0], lock_detect_i};
			acq_sync_ff  <= {acq_sync_ff[0], acq_state_i};
		end
	end

	// Link answer one cycle after the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 8'h00;
		end else if (ce_i) begin
			ack_ff <= access;
			if (access) begin
				rdata_ff <= link.addr == REG_CTRL ? ctrl_view : bw_view;
			end
		end
	end

	// Manual mode holds enable and flag clear; a lock change in the
	// clearing cycle still sets the flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_en_ff <= CTRL_RESET[CTRL_IRQ_EN];
			flag_ff   <= CTRL_RESET[CTRL_FLAG];
		end else if (ce_i && !auto_ff) begin
			irq_en_ff <= 1'b0;
			flag_ff   <= 1'b0;
		end else if (ce_i) begin
			if (wr_ctrl) begin
				irq_en_ff <= link.wdata[CTRL_IRQ_EN];
			end
			if (lock_change) begin
				flag_ff <= 1'b1;
			end else if (rd_ctrl) begin
				flag_ff <= 1'b0;
			end
		end
	end

	// Loop on and select guard each other against the old values,
	// so one write cannot both start the loop and select it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loop_on_ff   <= LOOP_ON_RESET;
			base_sel_ff  <= CTRL_RESET[CTRL_BASE_SEL];
			stop_prev_ff <= 1'b0;
		end else if (ce_i) begin
			stop_prev_ff <= link.stop_mode;
			if (base_sel_ff) begin
				loop_on_ff <= 1'b1;
			end else if (wr_ctrl) begin
				loop_on_ff <= link.wdata[CTRL_LOOP_ON];
			end
			if (!loop_on_ff || range_zero) begin
				base_sel_ff <= 1'b0;
			end else if (stop_entry) begin
				base_sel_ff <= 1'b0;
			end else if (wr_ctrl) begin
				base_sel_ff <= link.wdata[CTRL_BASE_SEL];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prescale_ff <= CTRL_RESET[CTRL_PRE_HI:CTRL_PRE_LO];
			vpr_ff      <= CTRL_RESET[CTRL_VPR_HI:CTRL_VPR_LO];
		end else if (ce_i && wr_ctrl && !loop_on_ff) begin
			prescale_ff <= link.wdata[CTRL_PRE_HI:CTRL_PRE_LO];
			// Code 11 is stored as written; avoiding it is software's job
			vpr_ff <= link.wdata[CTRL_VPR_HI:CTRL_VPR_LO];
		end
	end

	// Manual acquire value survives automatic mode and comes back after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			auto_ff    <= BW_RESET[BW_AUTO];
			acq_man_ff <= BW_RESET[BW_ACQ];
		end else if (ce_i && wr_bw) begin
			auto_ff <= link.wdata[BW_AUTO];
			if (!auto_ff) begin
				acq_man_ff <= link.wdata[BW_ACQ];
			end
		end
	end

	// Hand-over: drain old source, then arm new, output frozen meanwhile
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ho_ff         <= HO_RUN;
			edge_cnt_ff   <= 2'h0;
			active_sel_ff <= CTRL_RESET[CTRL_BASE_SEL];
		end else if (ce_i) begin
			unique case (ho_ff)
				HO_RUN: begin
					edge_cnt_ff <= 2'h0;
					if (base_sel_ff != active_sel_ff) begin
						ho_ff <= HO_DRAIN_OLD;
					end
				end
				HO_DRAIN_OLD: begin
					edge_cnt_ff <= edge_cnt_ff + {1'b0, old_rise};
					if (old_rise && edge_cnt_ff == HANDOVER_EDGES - 2'h1) begin
						edge_cnt_ff <= 2'h0;
						ho_ff       <= HO_ARM_NEW;
					end
				end
				HO_ARM_NEW: begin
					edge_cnt_ff <= edge_cnt_ff + {1'b0, new_rise};
					if (new_rise && edge_cnt_ff == HANDOVER_EDGES - 2'h1) begin
						active_sel_ff <= !active_sel_ff;
						ho_ff         <= HO_RUN;
					end
				end
			endcase
		end
	end

	// Toggling on each source edge gives half rate and even duty
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			base_ff <= 1'b0;
		end else if (ce_i) begin
			if (halted || !link.osc_enable_in) begin
				base_ff <= 1'b0;
			end else if (ho_ff == HO_RUN && old_rise) begin
				base_ff <= !base_ff;
			end
		end
	end

	assign link.ack             = ack_ff;
	assign link.rdata           = rdata_ff;
	assign link.base_clock_out  = base_ff;
	assign link.lock_change_irq = flag_ff && irq_en_ff && auto_ff
		&& link.osc_enable_in && !halted;
	assign osc_run_o   = link.osc_enable_in && !halted;
	assign pll_run_o   = loop_on_ff && link.osc_enable_in && !link.stop_mode;
	assign loop_on_o   = loop_on_ff;
	assign prescale_o  = prescale_ff;
	assign vco_pow2_o  = vpr_ff;
	assign auto_mode_o = auto_ff;
	assign acq_force_o = acq_man_ff;

endmodule

// ---- hdl/pll_sim_end.sv ----
// System integration end: classic Wishbone slave that forwards the two
// clock generator registers over the link, and owns oscillator enable,
// stop and keep-alive configuration. Assumes the same system clock.
`timescale 1ns/1ps
module pll_sim_end
	import pll_cgm_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq_o,
	output logic             base_clock_o,
	pll_link_if.sim          link
);
	import pll_cgm_pkg::*;

	logic [2:0]  cfg_ff;
	logic        ack_ff;
	logic [31:0] dat_ff;
	logic        req;
	logic        dev_hit;

	assign req     = wb_cyc_i && wb_stb_i;
	assign dev_hit = wb_adr_i == WB_CTRL || wb_adr_i == WB_BW;

	// Local registers and unmapped addresses answer one cycle later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0;
			cfg_ff <= CFG_RESET;
		end else if (ce_i) begin
			ack_ff <= req && !dev_hit && !ack_ff;
			if (req && !dev_hit && !ack_ff) begin
				dat_ff <= 32'h0;
				if (wb_adr_i == WB_SIM_CFG) begin
					dat_ff[2:0] <= cfg_ff;
					if (wb_we_i && wb_sel_i[0]) begin
						cfg_ff <= wb_dat_i[2:0];
					end
				end else if (wb_adr_i == WB_SIM_STAT) begin
					dat_ff[STAT_IRQ]      <= link.lock_change_irq;
					dat_ff[STAT_BASE_CLK] <= link.base_clock_out;
				end
			end
		end
	end

	// Byte lane 0 gates register writes; a disabled lane turns into a read
	assign link.req   = req && dev_hit;
	assign link.addr  = wb_adr_i == WB_BW ? REG_BW : REG_CTRL;
	assign link.we    = wb_we_i && wb_sel_i[0];
	assign link.wdata = wb_dat_i[7:0];

	assign wb_ack_o = dev_hit ? link.ack && req : ack_ff;
	assign wb_dat_o = dev_hit ? {24'h0, link.rdata} : dat_ff;

	assign link.osc_enable_in      = cfg_ff[CFG_OSC_EN];
	assign link.stop_mode          = cfg_ff[CFG_STOP];
	assign link.stop_osc_keepalive = cfg_ff[CFG_KEEPALIVE];

	assign irq_o        = link.lock_change_irq;
	assign base_clock_o = link.base_clock_out;

endmodule

// ---- bench/pll_clock_control_regs_checker.sv ----
// Checker on the link between the two clock generator ends.
// Assumes one clock, synchronous high reset, ce held high.
`timescale 1ns/1ps
module pll_clock_control_regs_checker
	import pll_cgm_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       req,
	input  wire logic       addr,
	input  wire logic       we,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] rdata,
	input  wire logic       ack,
	input  wire logic       osc_enable_in,
	input  wire logic       stop_mode,
	input  wire logic       stop_osc_keepalive,
	input  wire logic       base_clock_out,
	input  wire logic       lock_change_irq
);
	logic auto_ff;
	logic rd_ctrl;
	logic rd_bw;
	logic off;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	assign rd_ctrl = ack && !we && addr == REG_CTRL;
	assign rd_bw   = ack && !we && addr == REG_BW;
	assign off     = !osc_enable_in || (stop_mode && !stop_osc_keepalive);

	// Mode mirror lags the device by one edge; reads come later anyway
	always_ff @(posedge clk_i) begin
		if (rst_i)
			auto_ff <= 1'b0;
		else if (ack && req && we && addr == REG_BW)
			auto_ff <= wdata[BW_AUTO];
	end

	a_ack_single: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	a_answer_next: assert property ($rose(req) |=> ack)
		else $error("request not answered next cycle");
	a_ack_has_req: assert property (ack |-> $past(req))
		else $error("ack without request");
	a_irq_auto: assert property (lock_change_irq |-> auto_ff)
		else $error("interrupt in manual mode");
	a_irq_stop: assert property (off |-> !lock_change_irq)
		else $error("interrupt while stopped");
	a_base_idle: assert property (off [*4] |-> !base_clock_out)
		else $error("base clock runs while disabled");
	a_flag_manual: assert property (rd_ctrl && !auto_ff |->
		!rdata[CTRL_FLAG] && !rdata[CTRL_IRQ_EN])
		else $error("flag or enable read set in manual");
	a_lock_manual: assert property (rd_bw && !auto_ff |->
		!rdata[BW_LOCK])
		else $error("lock read set in manual");
	a_sel_loop: assert property (
		rd_ctrl && rdata[CTRL_BASE_SEL] |-> rdata[CTRL_LOOP_ON])
		else $error("select set with loop off");
	a_lock_zero: assert property (req && we && addr == REG_BW |->
		!wdata[BW_LOCK])
		else $error("lock bit written as one");
	a_bw_low: assert property (rd_bw |-> rdata[4:0] == 5'h00)
		else $error("unused bandwidth bits set");

	c_write: cover property (ack && we);
	c_irq: cover property (lock_change_irq);
	c_base: cover property ($rose(base_clock_out));
endmodule

// ---- bench/pll_clock_control_regs_tb_top.sv ----
// Bench: Wishbone master drives both clock generator ends joined by link.
// Assumes 50 MHz clk_i; source clocks are made here from clk_i edges.
`timescale 1ns/1ps
module pll_clock_control_regs_tb_top;
	import pll_cgm_pkg::*;
	logic        clk_i, rst_i, cyc, stb, wwe, irq, bclk;
	logic        xtal, vco, lock, acquire_track_select, osc_run, pll_run, loop_on;
	logic        auto_m, acq_f, ack;
	logic [1:0]  xc, vc, pre, vpr;
	logic [3:0]  sel;
	logic [7:0]  adr, rng, q;
	logic [31:0] dat, dat_o;
	int          num_errors, compares;

	pll_link_if link ();
	pll_clock_control_regs i_pll_clock_control_regs (.clk_i(clk_i),
		.rst_i(rst_i), .ce_i(1'b1), .link(link), .crystal_clock_i(xtal),
		.vco_clock_i(vco), .lock_detect_i(lock), .acq_state_i(acquire_track_select),
		.vco_range_field_i(rng), .osc_run_o(osc_run), .pll_run_o(pll_run),
		.loop_on_o(loop_on), .prescale_o(pre), .vco_pow2_o(vpr),
		.auto_mode_o(auto_m), .acq_force_o(acq_f));
	pll_sim_end i_pll_sim_end (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.irq_o(irq), .base_clock_o(bclk), .link(link));
	pll_clock_control_regs_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
		.req(link.req), .addr(link.addr), .we(link.we),
		.wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
		.osc_enable_in(link.osc_enable_in), .stop_mode(link.stop_mode),
		.stop_osc_keepalive(link.stop_osc_keepalive),
		.base_clock_out(link.base_clock_out),
		.lock_change_irq(link.lock_change_irq));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// Crystal period 8 clocks, VCO period 6 clocks
	always @(posedge clk_i) begin
		xc <= xc + 2'h1;
		vc <= (vc == 2'h2) ? 2'h0 : vc + 2'h1;
		if (xc == 2'h3)
			xtal <= ~xtal;
		if (vc == 2'h2)
			vco <= ~vco;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// No cycle count assumed: waits for ack, the watchdog ends a hang
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		wwe <= w;
		adr <= a;
		sel <= 4'h1;
		dat <= {24'h0, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		xfer(a, 1'b0, 8'h00);
		chk(q, exp);
	endtask

	// Toggles of the base clock over a window, within a tolerance
	task automatic tog(input int span, input int exp, input int tol);
		int  c;
		logic p;
		c = 0;
		p = bclk;
		repeat (span) begin
			@(posedge clk_i);
			if (bclk !== p)
				c++;
			p = bclk;
		end
		chk((c >= exp - tol && c <= exp + tol) ? 8'(exp) : 8'(c), 8'(exp));
	endtask

	task automatic summarize;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		summarize();
	end

	initial begin
		{cyc, stb, wwe, adr, sel, dat} = '0;
		{xtal, vco, xc, vc, lock, acquire_track_select} = '0;
		rng = 8'h40;
		rst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(WB_CTRL, CTRL_RESET);
		rdc(WB_BW, BW_RESET);
		rdc(WB_SIM_CFG, 8'h01);
		xfer(WB_CTRL, 1'b1, 8'h2e);
		rdc(WB_CTRL, 8'h20);
		xfer(WB_CTRL, 1'b1, 8'h00);
		rdc(WB_CTRL, 8'h00);
		xfer(WB_CTRL, 1'b1, 8'h3e);
		rdc(WB_CTRL, 8'h2e);
		chk({3'h0, loop_on, pre, vpr}, 8'h1e);
		xfer(WB_CTRL, 1'b1, 8'h3e);
		rdc(WB_CTRL, 8'h3e);
		xfer(WB_CTRL, 1'b1, 8'h1e);
		rdc(WB_CTRL, 8'h3e);
		repeat (80) @(posedge clk_i);
		tog(96, 16, 1);
		rng <= 8'h00;
		rdc(WB_CTRL, 8'h2e);
		rng <= 8'h40;
		repeat (80) @(posedge clk_i);
		tog(96, 12, 1);
		xfer(WB_CTRL, 1'b1, 8'h3e);
		repeat (80) @(posedge clk_i);
		xfer(WB_SIM_CFG, 1'b1, 8'h03);
		rdc(WB_CTRL, 8'h2e);
		chk({6'h0, osc_run, pll_run}, 8'h00);
		repeat (5) @(posedge clk_i);
		tog(48, 0, 0);
		xfer(WB_SIM_CFG, 1'b1, 8'h07);
		chk({6'h0, osc_run, pll_run}, 8'h02);
		repeat (10) @(posedge clk_i);
		tog(96, 12, 1);
		xfer(WB_SIM_CFG, 1'b1, 8'h00);
		repeat (5) @(posedge clk_i);
		tog(48, 0, 0);
		xfer(WB_SIM_CFG, 1'b1, 8'h01);
		xfer(WB_BW, 1'b1, 8'h80);
		rdc(WB_BW, 8'h80);
		xfer(WB_CTRL, 1'b1, 8'hae);
		rdc(WB_CTRL, 8'hae);
		lock <= 1'b1;
		repeat (8) @(posedge clk_i);
		xfer(WB_SIM_STAT, 1'b0, 8'h00);
		chk(q & 8'h01, 8'h01);
		rdc(WB_BW, 8'hc0);
		rdc(WB_CTRL, 8'hee);
		rdc(WB_CTRL, 8'hae);
		chk({7'h0, irq}, 8'h00);
		acquire_track_select <= 1'b1;
		repeat (6) @(posedge clk_i);
		rdc(WB_BW, 8'he0);
		xfer(WB_BW, 1'b1, 8'h00);
		rdc(WB_BW, 8'h00);
		chk({7'h0, auto_m}, 8'h00);
		rdc(WB_CTRL, 8'h2e);
		lock <= 1'b0;
		repeat (8) @(posedge clk_i);
		rdc(WB_CTRL, 8'h2e);
		xfer(WB_CTRL, 1'b1, 8'hae);
		rdc(WB_CTRL, 8'h2e);
		xfer(WB_BW, 1'b1, 8'h20);
		rdc(WB_BW, 8'h20);
		chk({7'h0, acq_f}, 8'h01);
		xfer(8'h10, 1'b1, 8'h5a);
		rdc(8'h10, 8'h00);
		summarize();
	end
endmodule
